// ==== shared/sent_tx_regs.svh ====
// Constants of the single-wire frame transmitter: offsets, fields, timing.
// Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef SENT_TX_REGS_SVH
`define SENT_TX_REGS_SVH

`define SENT_CTRL_OFF 8'h00
`define SENT_SAMPLE_OFF 8'h04
`define SENT_AUX_OFF 8'h08
`define SENT_STAT_OFF 8'h0C

`define SENT_CTRL_MODE_LSB 0
`define SENT_CTRL_RATE_LSB 4
`define SENT_CTRL_FMT_LSB 9
`define SENT_CTRL_CRCST_BIT 11
`define SENT_SAMPLE_TEMP_LSB 16
`define SENT_AUX_DSTAT_LSB 8
`define SENT_AUX_SER_LSB 10
`define SENT_STAT_BUSY_BIT 12
`define SENT_STAT_WAIT_BIT 13
`define SENT_STAT_PEND_BIT 14

`define SENT_CTRL_RESET 32'h0000_0000
`define SENT_SAMPLE_RESET 32'h0000_0000
`define SENT_AUX_RESET 32'h0000_0000

`define SENT_CLK_HZ 200000000
`define SENT_UPDATE_HZ 128000
`define SENT_UPD_CYC (`SENT_CLK_HZ / `SENT_UPDATE_HZ)
`define SENT_SYNC_TICKS 56
`define SENT_NIB_BASE 12
`define SENT_LOW_TICKS 5
`define SENT_PAUSE_MIN 12
`define SENT_GAP_TICKS 7
`define SENT_TRIG_MIN_NS 1800
`define SENT_TRIG_MIN_CYC ((`SENT_TRIG_MIN_NS * 200 + 999) / 1000)
`define SENT_PROC_NS 70400
`define SENT_PROC_CYC (`SENT_PROC_NS * (`SENT_CLK_HZ / 1000000) / 1000)
`define SENT_CRC_SEED 4'h5
`define SENT_CRC_POLY 4'hD
`define SENT_CNT_MAX_F1 12'h00F

`endif

// ==== shared/sent_tx_pkg.sv ====
// Types of the single-wire frame transmitter.
// Assumes nothing beyond a SystemVerilog compiler.
package sent_tx_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_WAIT  = 6'h02,
        ST_GAP   = 6'h04,
        ST_SYNC  = 6'h08,
        ST_NIB   = 6'h10,
        ST_PAUSE = 6'h20
    } state_t;

    typedef struct packed {
        logic crc_st;
        logic [1:0] fmt;
        logic [4:0] rate;
        logic [2:0] mode;
    } cfg_t;

    typedef struct packed {
        logic [11:0] temp;
        logic [11:0] field;
    } sample_t;

    typedef struct packed {
        logic [1:0] ser;
        logic [1:0] dstat;
        logic [7:0] diag;
    } aux_t;

    typedef logic [7:0][3:0] nibs_t;

endpackage

// ==== design/sent_frame_transmitter.sv ====
// Single-wire frame transmitter with AHB-Lite register slave.
// Assumes an external pull-up on the line and a synchronous AHB master.
`timescale 1ns/1ps
`include "sent_tx_regs.svh"

module sent_frame_transmitter #(
    parameter int PROC_CYC = `SENT_PROC_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sent_in,
    output logic sent_out,
    output logic sent_oe
);

////////////////////////////////////////////////////////////////////////////
// Helpers

function automatic logic [11:0] tick_cycles(logic [2:0] m, logic [4:0] r);
    logic [15:0] s;
    s = 16'(({11'h000, r} * 16'h00F4) / 16'h000A);
    if (m >= 3'h3) begin
        tick_cycles = (r == 5'h00) ? 12'h018 : s[11:0];
    end else begin
        case (r[3:0])
            4'h4: tick_cycles = 12'hB8A;
            4'h5: tick_cycles = 12'h788;
            4'h6: tick_cycles = 12'h5B8;
            4'h7: tick_cycles = 12'h4C4;
            4'h8: tick_cycles = 12'h3B8;
            4'h9: tick_cycles = 12'h2C4;
            4'hA: tick_cycles = 12'h1E8;
            4'hB: tick_cycles = 12'h156;
            4'hC: tick_cycles = 12'h0F4;
            4'hD: tick_cycles = 12'h0AA;
            4'hE: tick_cycles = 12'h07A;
            4'hF: tick_cycles = 12'h07A;
            default: tick_cycles = 12'h262;
        endcase
    end
endfunction

function automatic logic [3:0] crc_calc(sent_tx_pkg::nibs_t n,
                                        logic [2:0] last, logic st);
    logic [3:0] c;
    logic fb;
    c = `SENT_CRC_SEED;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
        if ((i > 0 || st) && 3'(i) < last) begin
            for (int b = 3; b >= 0; b--) begin
                fb = c[3];
                c = {c[2:0], n[i][b]} ^ (fb ? `SENT_CRC_POLY : 4'h0);
            end
        end
    end
    for (int b = 0; b < 4; b++) begin
        fb = c[3];
        c = {c[2:0], 1'b0} ^ (fb ? `SENT_CRC_POLY : 4'h0);
    end
    crc_calc = c;
endfunction

////////////////////////////////////////////////////////////////////////////
// Register slave

sent_tx_pkg::cfg_t cfg_ff, nxt_cfg;
sent_tx_pkg::sample_t live_ff, nxt_live;
sent_tx_pkg::aux_t aux_ff, nxt_aux;
logic wr_pend_ff, nxt_wr_pend;
logic [7:0] wr_addr_ff, nxt_wr_addr;
logic [31:0] rdata_ff, nxt_rdata;
logic addr_ph;
logic [31:0] stat_word;

sent_tx_pkg::state_t state_ff, nxt_state;
logic [11:0] cnt_ff, nxt_cnt;
logic pend_ff, nxt_pend;

assign addr_ph = hsel & hready & htrans[1];
assign stat_word = {17'h00000, pend_ff, state_ff == sent_tx_pkg::ST_WAIT,
                    state_ff[3] | state_ff[4] | state_ff[5], cnt_ff};

always_comb begin
    nxt_cfg = cfg_ff;
    nxt_live = live_ff;
    nxt_aux = aux_ff;
    nxt_wr_pend = addr_ph & hwrite;
    nxt_wr_addr = addr_ph ? haddr[7:0] : wr_addr_ff;
    nxt_rdata = 32'h0000_0000;
    if (wr_pend_ff) begin
        case (wr_addr_ff)
            `SENT_CTRL_OFF: nxt_cfg = {hwdata[11:4], hwdata[2:0]};
            `SENT_SAMPLE_OFF: nxt_live = {hwdata[27:16], hwdata[11:0]};
            `SENT_AUX_OFF: nxt_aux = hwdata[11:0];
            default: nxt_cfg = cfg_ff;
        endcase
    end
    if (addr_ph && !hwrite) begin
        case (haddr[7:0])
            `SENT_CTRL_OFF: nxt_rdata = {20'h00000, cfg_ff[10:3], 1'b0,
                                         cfg_ff[2:0]};
            `SENT_SAMPLE_OFF: nxt_rdata = {4'h0, live_ff.temp,
                                           4'h0, live_ff.field};
            `SENT_AUX_OFF: nxt_rdata = {20'h00000, aux_ff};
            `SENT_STAT_OFF: nxt_rdata = stat_word;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end
end

always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cfg_ff <= 11'(`SENT_CTRL_RESET);
        live_ff <= 24'(`SENT_SAMPLE_RESET);
        aux_ff <= 12'(`SENT_AUX_RESET);
        wr_pend_ff <= 1'b0;
        wr_addr_ff <= 8'h00;
        rdata_ff <= 32'h0000_0000;
    end else begin
        cfg_ff <= nxt_cfg;
        live_ff <= nxt_live;
        aux_ff <= nxt_aux;
        wr_pend_ff <= nxt_wr_pend;
        wr_addr_ff <= nxt_wr_addr;
        rdata_ff <= nxt_rdata;
    end
end

assign hrdata = rdata_ff;
assign hreadyout = 1'b1;
assign hresp = 1'b0;

////////////////////////////////////////////////////////////////////////////
// Line sampling

logic line_s1_ff, line_s2_ff, line_d_ff;
logic oe_ff, nxt_oe;

always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        line_s1_ff <= 1'b1;
        line_s2_ff <= 1'b1;
        line_d_ff <= 1'b1;
    end else begin
        line_s1_ff <= sent_in;
        line_s2_ff <= line_s1_ff;
        line_d_ff <= line_s2_ff;
    end
end

////////////////////////////////////////////////////////////////////////////
// Frame engine

logic [11:0] cyc_ff, nxt_cyc, tick_cyc;
logic [7:0] tcnt_ff, nxt_tcnt;
logic [10:0] upd_ff, nxt_upd;
logic [2:0] idx_ff, nxt_idx, last_ff, nxt_last;
sent_tx_pkg::nibs_t nib_ff, nxt_nib;
sent_tx_pkg::sample_t hold_ff, nxt_hold, src;
logic [19:0] sfall_ff, nxt_sfall, sync_cyc;
logic [8:0] low_ff, nxt_low;
logic armed_ff, nxt_armed;
logic tick, upd_tick, load, restart, fall, rise, low_ok;

assign tick_cyc = tick_cycles(cfg_ff.mode, cfg_ff.rate);
assign sync_cyc = {8'h00, tick_cyc} * 20'(`SENT_SYNC_TICKS);
assign tick = cyc_ff >= tick_cyc - 12'h001;
assign upd_tick = upd_ff == 11'(`SENT_UPD_CYC - 1);
assign fall = !oe_ff && line_d_ff && !line_s2_ff;
assign rise = !oe_ff && !line_d_ff && line_s2_ff;
assign low_ok = cfg_ff.mode != 3'h2 || low_ff >= 9'(`SENT_TRIG_MIN_CYC);
assign src = (cfg_ff.mode == 3'h1) ? live_ff : hold_ff;

always_comb begin
    nxt_state = state_ff;
    nxt_cyc = tick ? 12'h000 : cyc_ff + 12'h001;
    // Saturates so long gaps never wrap below the minimum
    nxt_tcnt = (tick && tcnt_ff != 8'hFF) ? tcnt_ff + 8'h01 : tcnt_ff;
    nxt_upd = upd_tick ? 11'h000 : upd_ff + 11'h001;
    nxt_idx = idx_ff;
    nxt_last = last_ff;
    nxt_nib = nib_ff;
    nxt_cnt = cnt_ff;
    nxt_hold = hold_ff;
    nxt_pend = pend_ff;
    nxt_armed = armed_ff;
    nxt_sfall = (sfall_ff == 20'hFFFFF) ? sfall_ff : sfall_ff + 20'h00001;
    nxt_low = (armed_ff && !line_s2_ff && low_ff != 9'h1FF) ?
              low_ff + 9'h001 : low_ff;
    load = 1'b0;
    restart = 1'b0;
    if (pend_ff && upd_tick) begin
        nxt_hold = live_ff;
        nxt_pend = 1'b0;
    end
    case (state_ff)
        sent_tx_pkg::ST_IDLE: begin
            if (cfg_ff.mode == 3'h1 && upd_tick) begin
                load = 1'b1;
            end else if (cfg_ff.mode >= 3'h2) begin
                nxt_state = sent_tx_pkg::ST_WAIT;
            end
        end
        sent_tx_pkg::ST_WAIT: begin
            if (cfg_ff.mode < 3'h2) begin
                nxt_state = sent_tx_pkg::ST_IDLE;
                nxt_armed = 1'b0;
            end else if (fall) begin
                nxt_armed = 1'b1;
                nxt_sfall = 20'h00000;
                nxt_low = 9'h000;
                nxt_pend = 1'b1;
            end else if (rise && armed_ff) begin
                nxt_armed = 1'b0;
                if (low_ok) begin
                    nxt_state = sent_tx_pkg::ST_GAP;
                    restart = 1'b1;
                end
            end
        end
        sent_tx_pkg::ST_GAP: begin
            if (tcnt_ff >= 8'(`SENT_GAP_TICKS) &&
                {1'b0, sfall_ff} + {1'b0, sync_cyc} >= 21'(PROC_CYC)) begin
                load = 1'b1;
            end
        end
        sent_tx_pkg::ST_SYNC: begin
            if (tick && tcnt_ff == 8'(`SENT_SYNC_TICKS - 1)) begin
                nxt_state = sent_tx_pkg::ST_NIB;
                nxt_idx = 3'h0;
                restart = 1'b1;
            end
        end
        sent_tx_pkg::ST_NIB: begin
            if (tick && tcnt_ff ==
                8'(`SENT_NIB_BASE - 1) + {4'h0, nib_ff[idx_ff]}) begin
                restart = 1'b1;
                if (idx_ff == last_ff) begin
                    nxt_state = sent_tx_pkg::ST_PAUSE;
                    if ((cfg_ff.fmt == 2'h1 && cnt_ff >= `SENT_CNT_MAX_F1)
                        || cnt_ff == 12'hFFF) begin
                        nxt_cnt = 12'h000;
                    end else begin
                        nxt_cnt = cnt_ff + 12'h001;
                    end
                end else begin
                    nxt_idx = idx_ff + 3'h1;
                end
            end
        end
        sent_tx_pkg::ST_PAUSE: begin
            if (tcnt_ff >= 8'(`SENT_PAUSE_MIN)) begin
                if (cfg_ff.mode == 3'h1) begin
                    load = upd_tick;
                end else begin
                    nxt_state = (cfg_ff.mode == 3'h0) ?
                        sent_tx_pkg::ST_IDLE : sent_tx_pkg::ST_WAIT;
                end
            end
        end
        default: nxt_state = sent_tx_pkg::ST_IDLE;
    endcase
    if (load) begin
        nxt_state = sent_tx_pkg::ST_SYNC;
        restart = 1'b1;
        nxt_nib = '0;
        nxt_nib[0] = {aux_ff.ser, aux_ff.dstat};
        nxt_nib[1] = src.field[11:8];
        nxt_nib[2] = src.field[7:4];
        nxt_nib[3] = src.field[3:0];
        case (cfg_ff.fmt)
            2'h1: {nxt_nib[4], nxt_nib[5], nxt_nib[6]} =
                  {aux_ff.diag, cnt_ff[3:0]};
            2'h2: {nxt_nib[4], nxt_nib[5], nxt_nib[6]} = cnt_ff;
            2'h3: {nxt_nib[4], nxt_nib[5], nxt_nib[6]} = src.temp;
            default: nxt_nib[4] = 4'h0;
        endcase
        nxt_last = (cfg_ff.fmt == 2'h0) ? 3'h4 : 3'h7;
        nxt_nib[nxt_last] = crc_calc(nxt_nib, nxt_last, cfg_ff.crc_st);
    end
    if (restart) begin
        nxt_cyc = 12'h000;
        nxt_tcnt = 8'h00;
    end
    nxt_oe = (nxt_state == sent_tx_pkg::ST_SYNC ||
              nxt_state == sent_tx_pkg::ST_NIB ||
              nxt_state == sent_tx_pkg::ST_PAUSE) &&
             nxt_tcnt < 8'(`SENT_LOW_TICKS);
end

always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_ff <= sent_tx_pkg::ST_IDLE;
        cyc_ff <= 12'h000;
        tcnt_ff <= 8'h00;
        upd_ff <= 11'h000;
        idx_ff <= 3'h0;
        last_ff <= 3'h4;
        nib_ff <= '0;
        cnt_ff <= 12'h000;
        hold_ff <= '0;
        pend_ff <= 1'b0;
        armed_ff <= 1'b0;
        sfall_ff <= 20'h00000;
        low_ff <= 9'h000;
        oe_ff <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        cyc_ff <= nxt_cyc;
        tcnt_ff <= nxt_tcnt;
        upd_ff <= nxt_upd;
        idx_ff <= nxt_idx;
        last_ff <= nxt_last;
        nib_ff <= nxt_nib;
        cnt_ff <= nxt_cnt;
        hold_ff <= nxt_hold;
        pend_ff <= nxt_pend;
        armed_ff <= nxt_armed;
        sfall_ff <= nxt_sfall;
        low_ff <= nxt_low;
        oe_ff <= nxt_oe;
    end
end

assign sent_out = 1'b0;
assign sent_oe = oe_ff;

////////////////////////////////////////////////////////////////////////////
// Checks

default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);

a_sync_len: assert property (
    state_ff == sent_tx_pkg::ST_SYNC && nxt_state == sent_tx_pkg::ST_NIB
    |-> tcnt_ff == 8'd55 && tick) else $error("sync length wrong");
a_sync_low: assert property (
    $rose(state_ff == sent_tx_pkg::ST_SYNC) |-> sent_oe)
    else $error("sync not starting low");
a_nib_len: assert property (
    state_ff == sent_tx_pkg::ST_NIB && restart
    |-> tcnt_ff == 8'd11 + {4'h0, nib_ff[idx_ff]})
    else $error("nibble length wrong");
a_nib_count: assert property (
    state_ff == sent_tx_pkg::ST_NIB && nxt_state == sent_tx_pkg::ST_PAUSE
    |-> idx_ff == (cfg_ff.fmt == 2'h0 ? 3'h4 : 3'h7))
    else $error("nibble count wrong");
a_gap_min: assert property (
    state_ff == sent_tx_pkg::ST_GAP ##1 state_ff == sent_tx_pkg::ST_SYNC
    |-> $past(tcnt_ff) >= 8'd7 && !$past(sent_oe))
    else $error("gap too short");
a_gap_proc: assert property (
    state_ff == sent_tx_pkg::ST_SYNC && nxt_state == sent_tx_pkg::ST_NIB
    && cfg_ff.mode >= 3'h2 |-> {1'b0, sfall_ff} >= 21'(PROC_CYC))
    else $error("processing time short");
a_wait_free: assert property (
    state_ff == sent_tx_pkg::ST_WAIT |-> !sent_oe)
    else $error("line driven while waiting");
a_wait_hold: assert property (
    state_ff == sent_tx_pkg::ST_WAIT && cfg_ff.mode >= 3'h2 && !rise
    |=> state_ff == sent_tx_pkg::ST_WAIT) else $error("left wait early");
a_cont_align: assert property (
    state_ff == sent_tx_pkg::ST_PAUSE ##1 state_ff == sent_tx_pkg::ST_SYNC
    |-> $past(upd_tick)) else $error("frame not on update");
a_latch: assert property (
    pend_ff && upd_tick |=> hold_ff == $past(live_ff) && !pend_ff)
    else $error("sample not latched");
a_cnt_wrap: assert property (
    state_ff == sent_tx_pkg::ST_NIB && nxt_state == sent_tx_pkg::ST_PAUSE
    && cfg_ff.fmt == 2'h1 && cnt_ff == 12'h00F |=> cnt_ff == 12'h000)
    else $error("count wrap wrong");

endmodule // sent_frame_transmitter

// ==== tb/sent_rx_model.sv ====
// Far-side controller: decodes frames and pulls the line for triggers.
// Assumes a pull-up on the line and the same clock as the transmitter.
`timescale 1ns/1ps
module sent_rx_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sent_oe,
    input wire logic sent_out,
    input wire logic [31:0] tick,
    input wire logic [31:0] nnib,
    output logic line,
    output sent_tx_pkg::nibs_t nibs,
    output logic [31:0] frames,
    output logic [31:0] pause_tk,
    output logic [31:0] bad_low,
    output logic [31:0] t_sync,
    output logic [31:0] t_pull,
    output logic [31:0] t_rel
);
    logic pull = 1'b0;
    logic oe_q;
    logic [31:0] now, t_last, cnt, tk;

    // Wired-AND of both drivers over the pull-up
    assign line = (sent_oe ? sent_out : 1'b1) & !pull;

    ////////////////////////////////////////////////////////////////////////
    // Falling edges made by the device; interval to the previous one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            now <= 0;
            oe_q <= 1'b0;
            t_last <= 0;
            cnt <= 99;
            frames <= 0;
            bad_low <= 0;
        end else begin
            now <= now + 1;
            oe_q <= sent_oe;
            tk = (now - t_last + tick / 2) / tick;
            if (sent_oe && !oe_q) begin
                t_last <= now;
                if (cnt == nnib) begin
                    pause_tk <= tk;
                    cnt <= 99;
                end else if (tk == 56) begin
                    cnt <= 0;
                    t_sync <= t_last;
                end else if (cnt < nnib) begin
                    nibs[cnt[2:0]] <= tk[3:0] - 4'hC;
                    cnt <= cnt + 1;
                    if (cnt + 1 == nnib) begin
                        frames <= frames + 1;
                    end
                end
            end
            if (!sent_oe && oe_q && now - t_last != 5 * tick) begin
                bad_low <= bad_low + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger request: hold low, then release
    task automatic trigger(input int len);
        @(posedge hclk);
        pull <= 1'b1;
        t_pull <= now;
        repeat (len) @(posedge hclk);
        pull <= 1'b0;
        t_rel <= now;
    endtask
endmodule // sent_rx_model

// ==== tb/sent_frame_transmitter_tb.sv ====
// Self-checking bench of the frame transmitter and its register slave.
// Assumes the far-side model and a shortened processing time.
`timescale 1ns/1ps
module sent_frame_transmitter_tb;
    localparam int PROC = 3000;
    localparam int UPD = 1562;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, tick = 24, nnib = 5;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, sent_in, sent_out, sent_oe;
    logic [31:0] frames, pause_tk, bad_low, t_sync, t_pull, t_rel;
    sent_tx_pkg::nibs_t nibs;
    logic [11:0] cnt = 0;
    int mismatches = 0, checked = 0;

    always #2.5 hclk = ~hclk;

    sent_frame_transmitter #(.PROC_CYC(PROC)) sent_frame_transmitter_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sent_in(sent_in),
        .sent_out(sent_out), .sent_oe(sent_oe));

    sent_rx_model sent_rx_model_inst (
        .hclk(hclk), .hresetn(hresetn), .sent_oe(sent_oe),
        .sent_out(sent_out), .tick(tick), .nnib(nnib), .line(sent_in),
        .nibs(nibs), .frames(frames), .pause_tk(pause_tk),
        .bad_low(bad_low), .t_sync(t_sync), .t_pull(t_pull), .t_rel(t_rel));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            check({31'h0, hreadyout}, 32'h1);
            print_verdict();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask

    task automatic wait_frames(input logic [31:0] n);
        for (int k = 0; k < 60000 && frames < n; k++) @(posedge hclk);
        if (frames < n) begin
            check(frames, n);
            print_verdict();
        end
    endtask

    // Polls status until the frame in flight has left its pause
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            ahb(1'b0, 8'h0C, 32'h0, rd);
            n++;
        end while (rd[12] !== 1'b0 && n < 2000);
        if (rd[12] !== 1'b0) begin
            check({31'h0, rd[12]}, 32'h0);
            print_verdict();
        end
    endtask

    function automatic logic [3:0] crc4(input logic [27:0] m, input int k);
        logic [31:0] x;
        logic [3:0] c;
        x = {m, 4'h0};
        c = 4'h5;
        for (int i = 4 * k + 3; i >= 0; i--) begin
            c = {c[2:0], x[i]} ^ (c[3] ? 4'hD : 4'h0);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // One frame: configure, request if triggered, decode and compare
    task automatic run_frame(input logic [2:0] md, input logic [1:0] fm,
                             input int len);
        logic [31:0] smp, ax, f0;
        logic [11:0] tl;
        logic [3:0] e [8];
        logic cs;
        int g, ex, nd;
        wait_done();
        cs = 1'($urandom);
        smp = $urandom & 32'h0FFF_0FFF;
        ax = $urandom & 32'h0000_0FFF;
        tick = md > 3'h2 ? 32'd24 : 32'd122;
        nd = fm == 2'h0 ? 3 : 6;
        nnib = nd + 2;
        f0 = frames;
        tl = fm == 2'h1 ? {ax[7:0], cnt[3:0]} : fm == 2'h2 ? cnt : smp[27:16];
        {e[0], e[1], e[2], e[3], e[4], e[5], e[6]} = {ax[11:8], smp[11:0], tl};
        e[nd + 1] = crc4(fm == 2'h0 ? {12'h0, ax[11:8], smp[11:0]}
                                    : {ax[11:8], smp[11:0], tl}, nd + cs);
        ahb(1'b1, 8'h04, smp, rd);
        ahb(1'b1, 8'h08, ax, rd);
        ahb(1'b1, 8'h00, {20'h0, cs, fm, md > 3'h2 ? 5'h01 : 5'h0E, 1'b0, md},
            rd);
        if (md != 3'h1) begin
            sent_rx_model_inst.trigger(len);
            repeat (1600 - len) @(posedge hclk);
            ahb(1'b1, 8'h04, ~smp & 32'h0FFF_0FFF, rd);
        end
        wait_frames(f0 + 1);
        if (md != 3'h1) begin
            g = int'(t_sync - t_rel);
            ex = PROC - 56 * int'(tick) - int'(t_rel - t_pull);
            if (ex < 7 * int'(tick)) begin
                ex = 7 * int'(tick);
            end
            check({31'h0, g >= ex && g <= ex + int'(tick) + 8}, 32'h1);
        end
        for (int i = 0; i < nd + 2; i++) begin
            check({28'h0, nibs[i]}, {28'h0, e[i]});
        end
        cnt = (fm == 2'h1 && cnt == 12'h00F) ? 12'h000 : cnt + 1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] msk [3];
        logic [31:0] v, f, ts;
        msk = '{32'h0000_0FF0, 32'h0FFF_0FFF, 32'h0000_0FFF};
        void'($urandom(52446));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, 32'h0);
        end
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
        for (int i = 4; i > 2; i--) begin
            ahb(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, 32'h0);
        end
        for (int i = 0; i < 3; i++) begin
            v = $urandom & msk[i];
            ahb(1'b1, 8'(4 * i), v, rd);
            ahb(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, v);
        end
        check(frames, 32'h0);
        for (int i = 0; i < 4; i++) begin
            run_frame(3'(3 + i % 2), 2'(i), 10 + $urandom % 40);
        end
        ahb(1'b0, 8'h0C, 32'h0, rd);
        check({20'h0, rd[11:0]}, {20'h0, cnt});
        wait_done();
        ahb(1'b1, 8'h00, 32'h0000_00E2, rd);
        f = frames;
        sent_rx_model_inst.trigger(100);
        repeat (2000) @(posedge hclk);
        check(frames, f);
        ahb(1'b0, 8'h0C, 32'h0, rd);
        check(rd, {17'h0, 3'b010, cnt});
        run_frame(3'h2, 2'h0, 800);
        run_frame(3'h1, 2'h0, 0);
        f = frames;
        ts = t_sync;
        wait_frames(f + 1);
        check({31'h0, pause_tk >= 12}, 32'h1);
        check((t_sync - ts) % UPD, 32'h0);
        check(bad_low, 32'h0);
        print_verdict();
    end
endmodule // sent_frame_transmitter_tb
